/* File: hdl/pmi_consts.svh */
`ifndef PMI_CONSTS_SVH
`define PMI_CONSTS_SVH
// register indices on the word pointer
`define PMI_REG_LIMIT    8'h07
`define PMI_REG_FLAGS    8'h08
`define PMI_REG_PINCTL   8'h09
`define PMI_PTR_RESET    8'h00
// field layout
`define PMI_FLAG_BUS_UNDER   0
`define PMI_FLAG_BUS_OVER    1
`define PMI_FLAG_SHUNT_UNDER 2
`define PMI_FLAG_SHUNT_OVER  3
`define PMI_LIMIT_LSB_MV     256
`define PMI_LIMIT_SHIFT      8
// reset values
`define PMI_UPPER_RESET  8'hFF
`define PMI_LOWER_RESET  8'h00
`define PMI_PINCTL_RESET 9'h000
// slave addressing: fixed upper part, broadcast
`define PMI_ADDR_FIXED   3'h4
`define PMI_ADDR_BCAST   7'h3F
// power-up quiet time before the serial port listens
`define PMI_CLK_NS       10
`define PMI_PWRUP_NS     1000
`define PMI_PWRUP_CYC    ((`PMI_PWRUP_NS + `PMI_CLK_NS - 1) / `PMI_CLK_NS)
`endif

/* File: hdl/pmi_pkg.sv */
package pmi_pkg;
  // one conversion result handed over by the measurement path
  typedef struct packed {
    logic        valid;
    logic [15:0] bus_mv;
    logic        shunt_over;
    logic        shunt_under;
  } pmi_conv_t;
  // clock-in/alert pin control word
  typedef struct packed {
    logic       force_alert;
    logic       alert_enable;
    logic       external_clock_select;
    logic [5:0] clock_divider_field;
  } pmi_pinctl_t;
  // strap level code per pin: 0 ground, 1 supply, 2 data line, 3 clock line
  typedef logic [1:0] pmi_strap_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b010,
    ST_RX   = 3'b011,
    ST_RACK = 3'b100,
    ST_TX   = 3'b101,
    ST_MACK = 3'b110
  } pmi_state_t;
endpackage : pmi_pkg

/* File: hdl/pmi_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pmi_consts.svh"
// Functional notes
// - limit register holds two 8-bit 256mV codes
// - compare each conversion once
// - exceeded limit sets sticky flag
// - writing one clears a flag
// - four flags: bus and shunt, under/over
// - flag bits 3..0, upper bits zero
// - force bit pulls alert pin low
// - enabled flags pull alert pin low
// - external clock makes pin input, oscillator off
// - internal clock is pin over 2*(div+1)
// - slave only, never drives clock
// - words travel high byte first
// - data changes while clock low only
// - idle after power-up until valid start
// - stop returns port to idle
// - address is fixed part plus straps
// - acknowledge address only on match
// - broadcast address accepted for writes only
// - pointer resets to 00h
// - write: pointer, high, low byte acked
// - read: repeated start, two bytes, master nacks
// - pointer increments after each sent word
// - works as SMBus slave at 100kHz
module pmi_top (
  input  wire logic                MCLK_I,
  input  wire logic                RESET_I,
  input  wire logic                SCL_I,
  input  wire logic                SDA_I,
  output var  logic                SDA_O,
  output var  logic                SDA_OE_O,
  input  wire pmi_pkg::pmi_strap_t STRAP_LOW_I,
  input  wire pmi_pkg::pmi_strap_t STRAP_HIGH_I,
  input  wire pmi_pkg::pmi_conv_t  CONV_I,
  input  wire logic                CKAL_I,
  output var  logic                CKAL_O,
  output var  logic                CKAL_OE_O,
  output var  logic                OSC_EN_O,
  output var  logic                INT_CLK_O
);
  import pmi_pkg::*;

  logic [2:0]  scl_sy_r, sda_sy_r, ck_sy_r;
  pmi_strap_t  stl_s1_r, stl_s2_r, sth_s1_r, sth_s2_r;
  logic [7:0]  pwr_cnt_r;
  logic        ready_r;
  logic [6:0]  own_addr_r;
  pmi_state_t  state_r;
  logic [3:0]  bit_cnt_r;
  logic [7:0]  shift_r, tx_sh_r, ptr_r, hi_r;
  logic [1:0]  rx_idx_r;
  logic        rd_r, byte_sel_r, mack_r;
  logic        wr_r;
  logic [7:0]  wr_addr_r;
  logic [15:0] wr_data_r;
  logic [7:0]  upper_r, lower_r;
  logic [3:0]  flags_r, flag_set, flag_clr;
  pmi_pinctl_t pinctl_r;
  logic [5:0]  div_cnt_r;
  logic        scl_rise, scl_fall, start_c, stop_c, ck_rise;
  logic [15:0] tx_word, tx_next_word;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers; SMBus lines are the same pins
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      scl_sy_r <= 3'h7;
      sda_sy_r <= 3'h7;
      ck_sy_r  <= 3'h7;                                          // pulled-up idle, no false rise
    end else begin
      scl_sy_r <= {scl_sy_r[1:0], SCL_I};
      sda_sy_r <= {sda_sy_r[1:0], SDA_I};
      ck_sy_r  <= {ck_sy_r[1:0], CKAL_I};
    end
  end

  // strap codes are pins too
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      stl_s1_r <= 2'h0;
      stl_s2_r <= 2'h0;
      sth_s1_r <= 2'h0;
      sth_s2_r <= 2'h0;
    end else begin
      stl_s1_r <= STRAP_LOW_I;
      stl_s2_r <= stl_s1_r;
      sth_s1_r <= STRAP_HIGH_I;
      sth_s2_r <= sth_s1_r;
    end
  end

  // edges read only stages 1 and 2 of each chain, never stage 0
  assign scl_rise = scl_sy_r[1] & ~scl_sy_r[2];
  assign scl_fall = ~scl_sy_r[1] & scl_sy_r[2];
  assign start_c  = scl_sy_r[1] & scl_sy_r[2] & ~sda_sy_r[1] & sda_sy_r[2];
  assign stop_c   = scl_sy_r[1] & scl_sy_r[2] & sda_sy_r[1] & ~sda_sy_r[2];
  assign ck_rise  = ck_sy_r[1] & ~ck_sy_r[2];

  ////////////////////////////////////////////////////////////////////////
  // power-up quiet time; straps are caught when it ends
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      pwr_cnt_r  <= 8'h00;
      ready_r    <= 1'b0;
      own_addr_r <= 7'h00;
    end else if (!ready_r) begin
      pwr_cnt_r <= pwr_cnt_r + 8'h01;
      if (pwr_cnt_r == 8'(`PMI_PWRUP_CYC)) begin
        ready_r    <= 1'b1;
        own_addr_r <= {`PMI_ADDR_FIXED, sth_s2_r, stl_s2_r};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register read mux; unmodelled or out-of-range locations read zero
  function automatic logic [15:0] rd_word(input logic [7:0] a);
    unique case (a)
      `PMI_REG_LIMIT:  rd_word = {upper_r, lower_r};
      `PMI_REG_FLAGS:  rd_word = {12'h000, flags_r};
      `PMI_REG_PINCTL: rd_word = {7'h00, pinctl_r};
      default:         rd_word = 16'h0000;
    endcase
  endfunction : rd_word

  assign tx_word      = rd_word(ptr_r);
  assign tx_next_word = rd_word(ptr_r + 8'h01);

  ////////////////////////////////////////////////////////////////////////
  // serial engine; sample on clock rise, change data on clock fall
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      state_r    <= ST_IDLE;
      bit_cnt_r  <= 4'h0;
      shift_r    <= 8'h00;
      tx_sh_r    <= 8'h00;
      hi_r       <= 8'h00;
      ptr_r      <= `PMI_PTR_RESET;
      rx_idx_r   <= 2'h0;
      rd_r       <= 1'b0;
      byte_sel_r <= 1'b0;
      mack_r     <= 1'b0;
      SDA_OE_O   <= 1'b0;
      wr_r       <= 1'b0;
      wr_addr_r  <= 8'h00;
      wr_data_r  <= 16'h0000;
    end else begin
      wr_r <= 1'b0;
      if (!ready_r) begin
        state_r  <= ST_IDLE;
        SDA_OE_O <= 1'b0;
      end else if (start_c) begin
        state_r   <= ST_ADDR;                                    // repeated start too
        bit_cnt_r <= 4'h0;
        SDA_OE_O  <= 1'b0;
      end else if (stop_c) begin
        state_r  <= ST_IDLE;
        SDA_OE_O <= 1'b0;
      end else begin
        unique case (state_r)
          ST_IDLE: ;
          ST_ADDR, ST_RX: begin
            if (scl_rise) begin
              shift_r   <= {shift_r[6:0], sda_sy_r[2]};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == 4'h8) begin
              bit_cnt_r <= 4'h0;
              if (state_r == ST_ADDR) begin
                // broadcast reads would collide, so they are not acked
                if (shift_r[7:1] == own_addr_r ||
                    (shift_r[7:1] == `PMI_ADDR_BCAST && !shift_r[0])) begin
                  rd_r     <= shift_r[0];
                  rx_idx_r <= 2'h0;
                  SDA_OE_O <= 1'b1;
                  state_r  <= ST_AACK;
                end else begin
                  state_r <= ST_IDLE;
                end
              end else begin
                state_r  <= ST_RACK;
                SDA_OE_O <= (rx_idx_r != 2'h3);
                if (rx_idx_r != 2'h3) begin
                  rx_idx_r <= rx_idx_r + 2'h1;
                end
                unique case (rx_idx_r)
                  2'h0: ptr_r <= shift_r;
                  2'h1: hi_r <= shift_r;
                  2'h2: begin
                    wr_r      <= 1'b1;
                    wr_addr_r <= ptr_r;
                    wr_data_r <= {hi_r, shift_r};
                  end
                  2'h3: ;
                endcase
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              bit_cnt_r <= 4'h0;
              if (rd_r) begin
                tx_sh_r    <= {tx_word[14:8], 1'b0};
                SDA_OE_O   <= ~tx_word[15];
                byte_sel_r <= 1'b0;
                state_r    <= ST_TX;
              end else begin
                SDA_OE_O <= 1'b0;
                state_r  <= ST_RX;
              end
            end
          end
          ST_RACK: begin
            if (scl_fall) begin
              SDA_OE_O <= 1'b0;
              state_r  <= ST_RX;
            end
          end
          ST_TX: begin
            // only the data line is ever driven, and only low
            if (scl_fall) begin
              bit_cnt_r <= bit_cnt_r + 4'h1;
              if (bit_cnt_r == 4'h7) begin
                SDA_OE_O <= 1'b0;
                state_r  <= ST_MACK;
              end else begin
                SDA_OE_O <= ~tx_sh_r[7];
                tx_sh_r  <= {tx_sh_r[6:0], 1'b0};
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              mack_r <= ~sda_sy_r[2];
            end else if (scl_fall) begin
              bit_cnt_r <= 4'h0;
              if (byte_sel_r) begin
                ptr_r <= ptr_r + 8'h01;
              end
              // nack ends the read; wait quietly for the stop
              if (!mack_r) begin
                state_r <= ST_IDLE;
              end else if (!byte_sel_r) begin
                tx_sh_r    <= {tx_word[6:0], 1'b0};
                SDA_OE_O   <= ~tx_word[7];
                byte_sel_r <= 1'b1;
                state_r    <= ST_TX;
              end else begin
                tx_sh_r    <= {tx_next_word[14:8], 1'b0};
                SDA_OE_O   <= ~tx_next_word[15];
                byte_sel_r <= 1'b0;
                state_r    <= ST_TX;
              end
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // writable registers
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      upper_r  <= `PMI_UPPER_RESET;
      lower_r  <= `PMI_LOWER_RESET;
      pinctl_r <= `PMI_PINCTL_RESET;
    end else if (wr_r) begin
      if (wr_addr_r == `PMI_REG_LIMIT) begin
        upper_r <= wr_data_r[15:8];
        lower_r <= wr_data_r[7:0];
      end
      if (wr_addr_r == `PMI_REG_PINCTL) begin
        pinctl_r <= wr_data_r[8:0];
      end
    end
  end

  // limit compare, once per conversion strobe; codes scale by 256mV
  always_comb begin
    flag_set = 4'h0;
    if (CONV_I.valid) begin
      flag_set[`PMI_FLAG_BUS_UNDER]   = CONV_I.bus_mv < {lower_r, 8'h00};
      flag_set[`PMI_FLAG_BUS_OVER]    = CONV_I.bus_mv > {upper_r, 8'hFF};
      flag_set[`PMI_FLAG_SHUNT_UNDER] = CONV_I.shunt_under;
      flag_set[`PMI_FLAG_SHUNT_OVER]  = CONV_I.shunt_over;
    end
    flag_clr = (wr_r && wr_addr_r == `PMI_REG_FLAGS) ? wr_data_r[3:0] : 4'h0;
  end

  // sticky flags; a new event wins over a clear in the same cycle
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      flags_r <= 4'h0;
    end else begin
      flags_r <= (flags_r & ~flag_clr) | flag_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shared pin: open-drain alert, or clock input
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      CKAL_O    <= 1'b0;
      CKAL_OE_O <= 1'b0;
      OSC_EN_O  <= 1'b1;
      SDA_O     <= 1'b0;
    end else begin
      CKAL_O    <= 1'b0;
      SDA_O     <= 1'b0;
      OSC_EN_O  <= ~pinctl_r.external_clock_select;
      CKAL_OE_O <= ~pinctl_r.external_clock_select &&
                   (pinctl_r.force_alert ||
                    (pinctl_r.alert_enable && |flags_r));
    end
  end

  // divider toggles every div+1 pin rises, period 2*(div+1)
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      div_cnt_r <= 6'h00;
      INT_CLK_O <= 1'b0;
    end else if (!pinctl_r.external_clock_select) begin
      div_cnt_r <= 6'h00;
      INT_CLK_O <= 1'b0;
    end else if (ck_rise) begin
      if (div_cnt_r >= pinctl_r.clock_divider_field) begin
        div_cnt_r <= 6'h00;
        INT_CLK_O <= ~INT_CLK_O;
      end else begin
        div_cnt_r <= div_cnt_r + 6'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);

  flag_sticky_a: assert property (flags_r[1] && !flag_clr[1] |=> flags_r[1])
    else $error("flag dropped without clear");
  flag_w1c_a: assert property (flag_clr[2] && !flag_set[2] |=> !flags_r[2])
    else $error("flag not cleared by one");
  over_cmp_a: assert property (CONV_I.valid && CONV_I.bus_mv > {upper_r, 8'hFF}
    |=> flags_r[`PMI_FLAG_BUS_OVER])
    else $error("over limit missed");
  force_pin_a: assert property (pinctl_r.force_alert && !pinctl_r.external_clock_select
    |=> CKAL_OE_O)
    else $error("force did not pull pin");
  alert_off_a: assert property (!pinctl_r.force_alert && !pinctl_r.alert_enable
    |=> !CKAL_OE_O)
    else $error("pin pulled while disabled");
  alert_flag_a: assert property (pinctl_r.alert_enable && |flags_r &&
    !pinctl_r.external_clock_select |=> CKAL_OE_O)
    else $error("set flag did not pull pin");
  ext_clk_a: assert property (pinctl_r.external_clock_select |=> !CKAL_OE_O && !OSC_EN_O)
    else $error("pin driven in clock mode");
  pwrup_idle_a: assert property (!ready_r |=> state_r == ST_IDLE && !SDA_OE_O)
    else $error("port active in power-up");
  stop_idle_a: assert property (ready_r && stop_c && !start_c |=> state_r == ST_IDLE)
    else $error("stop did not idle");
  ptr_inc_a: assert property (state_r == ST_MACK && scl_fall && byte_sel_r && !start_c
    && !stop_c |=> ptr_r == $past(ptr_r) + 8'h01)
    else $error("pointer not advanced");
  sda_drv_a: assert property (SDA_OE_O |-> state_r inside {ST_AACK, ST_RACK, ST_TX})
    else $error("data driven outside ack or send");

  wr_c: cover property (wr_r && wr_addr_r == `PMI_REG_LIMIT);
  rd_c: cover property (state_r == ST_MACK && byte_sel_r ##1 state_r == ST_TX);
  alert_c: cover property (pinctl_r.alert_enable && |flags_r ##1 CKAL_OE_O);
  div_c: cover property ($rose(INT_CLK_O));
endmodule : pmi_top
`default_nettype wire

/* File: dv/pmi_master.sv */
`timescale 1ns/10ps
`default_nettype none
// bus master that owns the serial clock and opens every transfer
module pmi_master #(
  parameter int HALF = 8
) (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_o
);
  // both lines released and still outside frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask : tick
  // data falls while the clock is high; also serves as repeated start
  task automatic start_cond();
    sda_o = 1'b1;
    tick(HALF / 2);
    scl_o = 1'b1;
    tick(HALF);
    sda_o = 1'b0;
    tick(HALF);
    scl_o = 1'b0;
    tick(HALF / 2);
  endtask : start_cond
  task automatic stop_cond();
    sda_o = 1'b0;
    tick(HALF / 2);
    scl_o = 1'b1;
    tick(HALF);
    sda_o = 1'b1;
    tick(HALF);
  endtask : stop_cond
  // one clock; data set mid-low, line sampled mid-high
  task automatic bit_xfer(input logic b, output logic seen);
    sda_o = b;
    tick(HALF / 2);
    scl_o = 1'b1;
    tick(HALF / 2);
    seen = sda_i;
    tick(HALF / 2);
    scl_o = 1'b0;
    tick(HALF / 2);
  endtask : bit_xfer
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], s);
    bit_xfer(1'b1, s);
    ack = ~s;
  endtask : send_byte
  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, s);
      d[i] = s;
    end
    bit_xfer(~ack, s);
  endtask : recv_byte
  // slave byte, pointer, high byte, low byte, then stop
  task automatic write_word(input logic [6:0] sa, input logic [7:0] ptr,
                            input logic [15:0] d, output logic [3:0] acks);
    start_cond();
    send_byte({sa, 1'b0}, acks[3]);
    send_byte(ptr, acks[2]);
    send_byte(d[15:8], acks[1]);
    send_byte(d[7:0], acks[0]);
    stop_cond();
  endtask : write_word
  // same slave address in both parts, never the broadcast one
  task automatic read_words(input logic [6:0] sa, input logic [7:0] ptr, input logic wp,
                            input int n, output logic [31:0] d, output logic [2:0] acks);
    logic [7:0] hi;
    logic [7:0] lo;
    d = '0;
    acks = 3'h7;
    start_cond();
    if (wp) begin
      send_byte({sa, 1'b0}, acks[2]);
      send_byte(ptr, acks[1]);
      start_cond();
    end
    send_byte({sa, 1'b1}, acks[0]);
    // ack each high byte, nack the last low byte
    for (int w = n; w > 0; w--) begin
      recv_byte(1'b1, hi);
      recv_byte(w != 1, lo);
      d = {d[15:0], hi, lo};
    end
    stop_cond();
  endtask : read_words
endmodule : pmi_master
`default_nettype wire

/* File: dv/pmi_top_test.sv */
`timescale 1ns/10ps
`default_nettype none
module pmi_top_test;
  import pmi_pkg::*;
  localparam logic [6:0] ADDR = 7'h46; // low strap on data line, high on supply
  logic      mclk = 1'b0;
  logic      rst = 1'b1;
  logic      scl;
  logic      m_sda;
  logic      ckal_drv = 1'b1;
  pmi_strap_t strap_lo = 2'h2;
  pmi_strap_t strap_hi = 2'h1;
  pmi_conv_t conv = '0;
  logic      sda_o, sda_oe, ckal_o, ckal_oe, osc_en, int_clk;
  logic      int_q = 1'b0;
  int        n_fail = 0;
  int        checks_done = 0;
  int        n_tog = 0;
  // both lines are open drain with pull-ups
  wire logic sda_w = m_sda & ~(sda_oe & ~sda_o);
  wire logic ckal_w = ckal_drv & ~(ckal_oe & ~ckal_o);
  ////////////////////////////////////////////////////////////////////////////
  pmi_top u_pmi_top (
    .MCLK_I(mclk), .RESET_I(rst), .SCL_I(scl), .SDA_I(sda_w),
    .SDA_O(sda_o), .SDA_OE_O(sda_oe), .STRAP_LOW_I(strap_lo), .STRAP_HIGH_I(strap_hi),
    .CONV_I(conv), .CKAL_I(ckal_w), .CKAL_O(ckal_o), .CKAL_OE_O(ckal_oe),
    .OSC_EN_O(osc_en), .INT_CLK_O(int_clk)
  );
  pmi_master u_pmi_master (.clk_i(mclk), .sda_i(sda_w), .scl_o(scl), .sda_o(m_sda));
  always #5 mclk = ~mclk;
  // count divided clock edges
  always @(posedge mclk) begin
    if (int_clk !== int_q) n_tog++;
    int_q <= int_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  task automatic wr(input logic [7:0] ptr, input logic [15:0] d);
    logic [3:0] a;
    u_pmi_master.write_word(ADDR, ptr, d, a);
    check("write acks", 16'h000F, {12'h0, a});
  endtask : wr
  task automatic rd(input logic [7:0] ptr, input logic wp, input int n, output logic [31:0] d);
    logic [2:0] a;
    u_pmi_master.read_words(ADDR, ptr, wp, n, d, a);
    check("read acks", 16'h0007, {13'h0, a});
  endtask : rd
  task automatic conv_pulse(input logic [15:0] mv, input logic so, input logic su);
    @(negedge mclk);
    conv = '{valid: 1'b1, bus_mv: mv, shunt_over: so, shunt_under: su};
    @(negedge mclk);
    conv.valid = 1'b0;
    repeat (2) @(negedge mclk);
  endtask : conv_pulse
  ////////////////////////////////////////////////////////////////////////////
  // a start inside the quiet time must draw no answer
  task automatic test_powerup();
    logic a;
    check("data drive", 16'h0, {15'h0, sda_oe});
    check("data level", 16'h0, {15'h0, sda_o});
    check("alert level", 16'h0, {15'h0, ckal_o});
    check("alert drive", 16'h0, {15'h0, ckal_oe});
    check("osc enable", 16'h1, {15'h0, osc_en});
    u_pmi_master.start_cond();
    u_pmi_master.send_byte({ADDR, 1'b0}, a);
    u_pmi_master.stop_cond();
    check("early ack", 16'h0, {15'h0, a});
    repeat (120) @(negedge mclk);
    $display("test powerup done");
  endtask : test_powerup
  task automatic test_limit();
    logic [31:0] d;
    logic [3:0]  a;
    rd(8'h00, 1'b0, 1, d);
    check("current read", 16'h0000, d[15:0]);
    rd(8'h07, 1'b1, 1, d);
    check("limit reset", 16'hFF00, d[15:0]);
    wr(8'h07, 16'h1234);
    rd(8'h07, 1'b1, 2, d);
    check("limit word", 16'h1234, d[31:16]);
    check("next word", 16'h0000, d[15:0]);
    u_pmi_master.write_word(7'h3F, 8'h07, 16'h1008, a);
    check("broadcast acks", 16'h000F, {12'h0, a});
    u_pmi_master.write_word(7'h47, 8'h07, 16'hFFFF, a);
    check("foreign acks", 16'h0000, {12'h0, a});
    rd(8'h07, 1'b1, 1, d);
    check("limit kept", 16'h1008, d[15:0]);
    $display("test limit done");
  endtask : test_limit
  // limits are lower 2048 mV, upper step top 4351 mV
  task automatic test_flags();
    logic [31:0] d;
    conv_pulse(16'h0800, 1'b0, 1'b0);
    conv_pulse(16'h10FF, 1'b0, 1'b0);
    rd(8'h08, 1'b1, 1, d);
    check("flags quiet", 16'h0000, d[15:0]);
    conv_pulse(16'h07FF, 1'b0, 1'b0);
    rd(8'h08, 1'b1, 1, d);
    check("under flag", 16'h0001, d[15:0]);
    conv_pulse(16'h1100, 1'b1, 1'b0);
    conv_pulse(16'h0BB8, 1'b0, 1'b1);
    rd(8'h07, 1'b1, 1, d);
    rd(8'h00, 1'b0, 1, d);
    check("all flags", 16'h000F, d[15:0]);
    wr(8'h08, 16'hFFF5);
    rd(8'h08, 1'b1, 1, d);
    check("flags cleared", 16'h000A, d[15:0]);
    $display("test flags done");
  endtask : test_flags
  task automatic test_alert();
    logic [31:0] d;
    wr(8'h09, 16'h0080);
    check("alert by flag", 16'h1, {15'h0, ckal_oe});
    wr(8'h08, 16'h000F);
    check("alert after clear", 16'h0, {15'h0, ckal_oe});
    wr(8'h09, 16'h0100);
    check("forced alert", 16'h1, {15'h0, ckal_oe});
    rd(8'h09, 1'b1, 1, d);
    check("control word", 16'h0100, d[15:0]);
    wr(8'h09, 16'h0000);
    conv_pulse(16'h0000, 1'b0, 1'b0);
    check("alert masked", 16'h0, {15'h0, ckal_oe});
    $display("test alert done");
  endtask : test_alert
  // divider field 1: one divided toggle per two pin rises
  task automatic test_extclk();
    wr(8'h09, 16'h0041);
    check("osc off", 16'h0, {15'h0, osc_en});
    check("pin released", 16'h0, {15'h0, ckal_oe});
    n_tog = 0;
    repeat (16) begin
      repeat (10) @(negedge mclk);
      ckal_drv = 1'b0;
      repeat (10) @(negedge mclk);
      ckal_drv = 1'b1;
    end
    repeat (10) @(negedge mclk);
    check("divided toggles", 16'h0008, n_tog[15:0]);
    $display("test extclk done");
  endtask : test_extclk
  // new strap codes only count from the next power-up; registers return to reset
  task automatic test_straps();
    logic [31:0] d;
    logic [2:0]  a;
    strap_lo = 2'h3;
    strap_hi = 2'h2;
    rst = 1'b1;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    check("reset data drive", 16'h0, {15'h0, sda_oe});
    repeat (110) @(negedge mclk);
    u_pmi_master.read_words(7'h4B, 8'h07, 1'b1, 1, d, a);
    check("strap acks", 16'h0007, {13'h0, a});
    check("limit after reset", 16'hFF00, d[15:0]);
    u_pmi_master.read_words(ADDR, 8'h07, 1'b1, 1, d, a);
    check("old address acks", 16'h0000, {13'h0, a});
    $display("test straps done");
  endtask : test_straps
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    test_powerup();
    test_limit();
    test_flags();
    test_alert();
    test_extclk();
    test_straps();
    complete_run();
  end
  // traffic takes about 16k cycles; give up after 50k
  initial begin
    #500000;
    n_fail++;
    complete_run();
  end
endmodule : pmi_top_test
`default_nettype wire
